//--- inc/ufp_pkg.sv
package ufp_pkg;
    // Register offsets on the management port
    localparam logic [7:0] UFP_OFS_PRIO_QUEUE = 8'h82;
    localparam logic [7:0] UFP_OFS_UNICAST = 8'h83;
    localparam logic [7:0] UFP_OFS_DRIVE_MCAST = 8'h84;
    localparam logic [7:0] UFP_OFS_VLAN = 8'h85;
    localparam logic [7:0] UFP_OFS_SELF_IPMC = 8'h86;

    // Field positions
    localparam int UFP_BIT_FWD_EN = 5;
    localparam int UFP_BIT_SELF_EN = 6;
    localparam int UFP_POS_DRIVE = 6;
    localparam int UFP_POS_PRIO2Q = 6;
    localparam int UFP_POS_PQ_RSVD = 2;
    localparam int UFP_MAP_W = 5;
    localparam int UFP_PORTS = 4;

    // Values after reset and fixed reserved read-backs
    localparam logic [1:0] UFP_RST_DRIVE = 2'h1;
    localparam logic [1:0] UFP_RST_PRIO2Q = 2'h2;
    localparam logic [1:0] UFP_PQ_RSVD_VAL = 2'h1;
    localparam logic [4:0] UFP_RST_MAP = 5'h00;

    // Class of a frame that missed a lookup table
    typedef enum logic [1:0] {
        UFP_CLS_UNICAST = 2'h0,
        UFP_CLS_MCAST = 2'h1,
        UFP_CLS_VLAN = 2'h2,
        UFP_CLS_IPMC = 2'h3
    } ufp_class_e;
endpackage

//--- inc/ufp_dec_if.sv
`timescale 1ns/1ps
interface ufp_dec_if;
    import ufp_pkg::*;
    logic en;
    logic [UFP_MAP_W-1:0] map;
    logic special;
    logic drop;
    logic [UFP_PORTS-1:0] mask;
    modport ctrl (output en, output map, input special, input drop, input mask);
    modport dec (input en, input map, output special, output drop, output mask);
endinterface

//--- hdl/ufp_map_dec.sv
`timescale 1ns/1ps
module ufp_map_dec
    import ufp_pkg::*;
(
    ufp_dec_if.dec d
);
    // Port map decode; bit 0 is never looked at, so 00001 lands on drop
    always_comb begin
        d.special = d.en;
        d.mask = d.map[UFP_MAP_W-1:1];
        d.drop = d.en && (d.map[UFP_MAP_W-1:1] == '0);
    end
endmodule // ufp_map_dec

//--- hdl/ufp_top.sv
`timescale 1ns/1ps
// How it works
// - Unicast enable bit 5 applies the unicast port map to missed unicast frames.
// - Map bits 4..1 zero drop (00000 or 00001); otherwise each of them picks one of ports 1 to 4.
// - Separate bit 5 enables special forwarding of unknown non-IP multicast.
// - Non-IP multicast map uses the same code set as unicast.
// - Bit 5 enables forwarding of frames with unknown VLAN ID.
// - Unknown-VLAN map uses the shared codes; zero drops.
// - Bit 5 enables special forwarding of unknown IP multicast.
// - IP multicast map uses the shared codes; zero drops.
// - Self filter bit 6 discards frames addressed to own MAC.
// - Self check is done at egress against the own MAC input.
// - Two-bit drive select held, resets to 01, driven to pads.
module ufp_top
    import ufp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic miss_valid,
    input wire logic [1:0] miss_class,
    output logic fwd_valid,
    output logic fwd_special,
    output logic fwd_drop,
    output logic [UFP_PORTS-1:0] fwd_mask,
    input wire logic [47:0] own_mac,
    input wire logic egr_valid,
    input wire logic [47:0] egr_dst_addr,
    output logic egr_result_valid,
    output logic egr_discard,
    output logic [1:0] pad_drive_sel
);
    typedef struct packed {
        // Stored register fields
        logic [1:0] prio2q;
        logic uc_en;
        logic [4:0] uc_map;
        logic [1:0] drive;
        logic mc_en;
        logic [4:0] mc_map;
        logic vid_en;
        logic [4:0] vid_map;
        logic self_en;
        logic ip_en;
        logic [4:0] ip_map;

        // Registered answers; every output port except pad_drive_sel reads one of these
        logic [7:0] rdata;
        logic rvalid;
        logic fvalid;
        logic fspecial;
        logic fdrop;
        logic [UFP_PORTS-1:0] fmask;
        logic evalid;
        logic ediscard;
    } ufp_state_s;

    // Current state and the value it takes at the next edge
    ufp_state_s r;
    ufp_state_s next_r;
    ufp_dec_if dec_bus ();
    ufp_class_e cls;

    // All four class codes are legal, so the cast never yields an unlisted class
    assign cls = ufp_class_e'(miss_class);

    // One decoder serves all classes; only one miss is judged per cycle.
    // Sharing it costs one mux but saves three copies of the map decode.
    always_comb begin
        dec_bus.en = 1'b0;
        dec_bus.map = '0;
        unique case (cls)
            UFP_CLS_UNICAST: begin
                dec_bus.en = r.uc_en;
                dec_bus.map = r.uc_map;
            end
            UFP_CLS_MCAST: begin
                dec_bus.en = r.mc_en;
                dec_bus.map = r.mc_map;
            end
            UFP_CLS_VLAN: begin
                dec_bus.en = r.vid_en;
                dec_bus.map = r.vid_map;
            end
            UFP_CLS_IPMC: begin
                dec_bus.en = r.ip_en;
                dec_bus.map = r.ip_map;
            end
        endcase
    end

    // Map decoder; bit 0 of the map is left out of the decision
    ufp_map_dec u_dec (
        .d(dec_bus.dec)
    );

    // Register access, decision capture and egress self check
    always_comb begin
        next_r = r;
        // Strobes turn into one-cycle answers one edge later
        next_r.rvalid = reg_rd;
        next_r.fvalid = miss_valid;
        next_r.evalid = egr_valid;
        // Read data is built from stored fields; reserved bits keep fixed values
        if (reg_rd) begin
            unique case (reg_addr)
                UFP_OFS_PRIO_QUEUE: begin
                    next_r.rdata = 8'h00;
                    next_r.rdata[UFP_POS_PRIO2Q +: 2] = r.prio2q;
                    next_r.rdata[UFP_POS_PQ_RSVD +: 2] = UFP_PQ_RSVD_VAL;
                end
                UFP_OFS_UNICAST: begin
                    next_r.rdata = 8'h00;
                    next_r.rdata[UFP_BIT_FWD_EN] = r.uc_en;
                    next_r.rdata[UFP_MAP_W-1:0] = r.uc_map;
                end
                UFP_OFS_DRIVE_MCAST: begin
                    next_r.rdata = 8'h00;
                    next_r.rdata[UFP_POS_DRIVE +: 2] = r.drive;
                    next_r.rdata[UFP_BIT_FWD_EN] = r.mc_en;
                    next_r.rdata[UFP_MAP_W-1:0] = r.mc_map;
                end
                UFP_OFS_VLAN: begin
                    next_r.rdata = 8'h00;
                    next_r.rdata[UFP_BIT_FWD_EN] = r.vid_en;
                    next_r.rdata[UFP_MAP_W-1:0] = r.vid_map;
                end
                UFP_OFS_SELF_IPMC: begin
                    next_r.rdata = 8'h00;
                    next_r.rdata[UFP_BIT_SELF_EN] = r.self_en;
                    next_r.rdata[UFP_BIT_FWD_EN] = r.ip_en;
                    next_r.rdata[UFP_MAP_W-1:0] = r.ip_map;
                end
                default: begin
                    next_r.rdata = 8'h00; // Unmapped reads return zero
                end
            endcase
        end

        // Reserved bits are simply not stored, so writes cannot disturb them.
        // A read in the same cycle as a write still returns the old value.
        if (reg_wr) begin
            unique case (reg_addr)
                UFP_OFS_PRIO_QUEUE: begin
                    next_r.prio2q = reg_wdata[UFP_POS_PRIO2Q +: 2];
                end
                UFP_OFS_UNICAST: begin
                    next_r.uc_en = reg_wdata[UFP_BIT_FWD_EN];
                    next_r.uc_map = reg_wdata[UFP_MAP_W-1:0];
                end
                UFP_OFS_DRIVE_MCAST: begin
                    next_r.drive = reg_wdata[UFP_POS_DRIVE +: 2];
                    next_r.mc_en = reg_wdata[UFP_BIT_FWD_EN];
                    next_r.mc_map = reg_wdata[UFP_MAP_W-1:0];
                end
                UFP_OFS_VLAN: begin
                    next_r.vid_en = reg_wdata[UFP_BIT_FWD_EN];
                    next_r.vid_map = reg_wdata[UFP_MAP_W-1:0];
                end
                UFP_OFS_SELF_IPMC: begin
                    next_r.self_en = reg_wdata[UFP_BIT_SELF_EN];
                    next_r.ip_en = reg_wdata[UFP_BIT_FWD_EN];
                    next_r.ip_map = reg_wdata[UFP_MAP_W-1:0];
                end
                default: begin
                    next_r.prio2q = r.prio2q; // Unmapped writes are dropped
                end
            endcase
        end

        // Decision for a missed frame; disabled class leaves mask empty.
        // Nothing clears the decision between frames: it holds until the next.
        if (miss_valid) begin
            next_r.fspecial = dec_bus.special;
            next_r.fdrop = dec_bus.drop;
            next_r.fmask = dec_bus.special ? dec_bus.mask : '0;
        end

        // Own address compare at the egress side. All 48 bits are compared,
        // so a multicast own address is filtered as well as a unicast one.
        if (egr_valid) begin
            next_r.ediscard = r.self_en && (egr_dst_addr == own_mac);
        end
    end

    // Synchronous reset to the power-up defaults; the maps are restated after
    // the blanket clear so a changed reset value in the package reaches them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
            r.drive <= UFP_RST_DRIVE;
            r.prio2q <= UFP_RST_PRIO2Q;
            r.uc_map <= UFP_RST_MAP;
            r.mc_map <= UFP_RST_MAP;
            r.vid_map <= UFP_RST_MAP;
            r.ip_map <= UFP_RST_MAP;
        end else begin
            r <= next_r;
        end
    end

    // All outputs come straight from the state register
    assign reg_rdata = r.rdata;
    assign reg_rvalid = r.rvalid;

    // Frame decisions, egress verdict and pad control
    assign fwd_valid = r.fvalid;
    assign fwd_special = r.fspecial;
    assign fwd_drop = r.fdrop;
    assign fwd_mask = r.fmask;
    assign egr_result_valid = r.evalid;
    assign egr_discard = r.ediscard;
    assign pad_drive_sel = r.drive;
endmodule // ufp_top

//--- verif/ufp_assertions.sv
`timescale 1ns/1ps
module ufp_assertions
    import ufp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic miss_valid,
    input wire logic fwd_valid,
    input wire logic fwd_special,
    input wire logic fwd_drop,
    input wire logic [UFP_PORTS-1:0] fwd_mask,
    input wire logic [47:0] own_mac,
    input wire logic egr_valid,
    input wire logic [47:0] egr_dst_addr,
    input wire logic egr_result_valid,
    input wire logic egr_discard,
    input wire logic [1:0] pad_drive_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Every answer lands exactly one edge after its request
    a_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read unanswered");
    a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
        else $error("stray rvalid");
    a_rdata_hold: assert property ($changed(reg_rdata) |-> reg_rvalid)
        else $error("rdata moved");
    a_miss_answer: assert property (fwd_valid == $past(miss_valid))
        else $error("fwd timing");
    a_egr_answer: assert property (egr_result_valid == $past(egr_valid))
        else $error("egr timing");
    // Decision outputs must agree with each other and with past inputs; drive select must reset to 01
    a_drop_empty: assert property (fwd_valid && fwd_drop |->
        fwd_special && fwd_mask == 4'h0) else $error("drop with mask");
    a_off_quiet: assert property (fwd_valid && !fwd_special |->
        !fwd_drop && fwd_mask == 4'h0) else $error("disabled class acted");
    a_mask_held: assert property (!fwd_valid |-> $stable(fwd_mask))
        else $error("mask moved");
    a_self_match: assert property (egr_result_valid && egr_discard |->
        $past(egr_dst_addr) == $past(own_mac)) else $error("discard on foreign addr");
    a_drive_reset: assert property ($rose(rst_n) |-> pad_drive_sel == 2'h1)
        else $error("drive");
endmodule // ufp_assertions

bind ufp_top ufp_assertions u_chk (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .miss_valid(miss_valid),
    .fwd_valid(fwd_valid), .fwd_special(fwd_special), .fwd_drop(fwd_drop),
    .fwd_mask(fwd_mask), .own_mac(own_mac), .egr_valid(egr_valid),
    .egr_dst_addr(egr_dst_addr), .egr_result_valid(egr_result_valid),
    .egr_discard(egr_discard), .pad_drive_sel(pad_drive_sel));

//--- verif/test_ufp_top.sv
`timescale 1ns/1ps
module test_ufp_top;
    import ufp_pkg::*;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, miss_valid = 0, egr_valid = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] miss_class = 2'h0, pad_drive_sel;
    logic [47:0] own_mac = 48'h0, egr_dst_addr = 48'h0;
    logic reg_rvalid, fwd_valid, fwd_special, fwd_drop, egr_result_valid, egr_discard;
    logic [3:0] fwd_mask;
    logic [7:0] shadow [4]; // Bench copy of 0x83..0x86
    logic [7:0] d;
    int num_errors = 0, n_compared = 0, seed = 32'h0468, c;
    ufp_top DUT (
        .clk(clk),
        .rst_n(rst_n),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .miss_valid(miss_valid),
        .miss_class(miss_class),
        .fwd_valid(fwd_valid),
        .fwd_special(fwd_special),
        .fwd_drop(fwd_drop),
        .fwd_mask(fwd_mask),
        .own_mac(own_mac),
        .egr_valid(egr_valid),
        .egr_dst_addr(egr_dst_addr),
        .egr_result_valid(egr_result_valid),
        .egr_discard(egr_discard),
        .pad_drive_sel(pad_drive_sel)
    );
    initial forever #2.5 clk = ~clk;
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task give_verdict;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Bits a register keeps; reserved ones read back as zero
    function automatic logic [7:0] kept(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] m;
        m = (a == 8'h84) ? 8'hFF : (a == 8'h86) ? 8'h7F : 8'h3F;
        return v & m;
    endfunction
    // Hand-picked map codes: drop, reserved, each listed code and one unlisted
    function automatic logic [4:0] hand_map(input int j);
        logic [4:0] codes [7];
        codes = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h07, 5'h1F, 5'h09};
        return codes[j / 2];
    endfunction
    // Ports a missed frame goes to: map bits 4..1, none when the class is off
    function automatic logic [3:0] exp_mask(input logic [7:0] r);
        return r[5] ? r[4:1] : 4'h0;
    endfunction
    // Reserved bits never stick, so the shadow keeps only writable ones
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk); #1;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = v;
        if (a > 8'h82 && a < 8'h87) begin
            shadow[a - 8'h83] = kept(a, v);
        end
        @(posedge clk); #1;
        reg_wr = 0;
        chk("drive", pad_drive_sel, shadow[1][7:6]);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk); #1;
        reg_rd = 1;
        reg_addr = a;
        @(posedge clk); #1;
        reg_rd = 0;
        chk("rvalid", reg_rvalid, 8'h01);
        chk("rdata", reg_rdata, exp);
    endtask
    task rdall;
        for (int i = 0; i < 4; i++) rd(8'h83 + 8'(i), shadow[i]);
    endtask
    // Expected decision comes from the bench's own register copy
    task miss(input int k);
        logic [7:0] r;
        r = shadow[k];
        @(posedge clk); #1;
        miss_valid = 1;
        miss_class = 2'(k);
        @(posedge clk); #1;
        miss_valid = 0;
        chk("fwd_valid", fwd_valid, 8'h01);
        chk("special", fwd_special, r[5]);
        chk("drop", fwd_drop, r[5] && r[4:1] == 4'h0);
        chk("mask", fwd_mask, exp_mask(r));
    endtask
    task egr(input logic [47:0] a);
        @(posedge clk); #1;
        egr_valid = 1;
        egr_dst_addr = a;
        @(posedge clk); #1;
        egr_valid = 0;
        chk("egr_valid", egr_result_valid, 8'h01);
        chk("discard", egr_discard, shadow[3][6] && a == own_mac);
    endtask
    initial begin
        shadow = '{8'h00, 8'h40, 8'h00, 8'h00};
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        rd(8'h82, 8'h84);
        rd(8'h87, 8'h00);
        rdall();
        own_mac = 48'({$random(seed), $random(seed)});
        // Hand-picked codes, reserved low bit included, enabled and disabled
        foreach (shadow[k]) for (int j = 0; j < 14; j++) begin
            d = {2'h1, j[0], hand_map(j)};
            wr(8'h83 + 8'(k), d);
            miss(k);
        end
        wr(8'h82, 8'hFF);
        rd(8'h82, 8'hC4);
        for (int i = 0; i < 4; i++) wr(8'h83 + 8'(i), 8'hFF);
        rdall();
        egr(own_mac);
        egr(own_mac ^ 48'h1);
        repeat (60) begin
            c = $random(seed) & 3;
            wr(8'h83 + 8'(c), 8'($random(seed)));
            miss(c);
            egr($random(seed) & 1 ? own_mac : 48'({$random(seed), $random(seed)}));
        end
        // An unmapped write must leave registers 0x83..0x86 alone
        wr(8'h87, 8'hFF);
        rdall();
        rst_n = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        shadow = '{8'h00, 8'h40, 8'h00, 8'h00};
        rdall();
        rd(8'h82, 8'h84);
        give_verdict();
    end
    // Watchdog well past the expected run length
    initial begin
        #40000;
        num_errors++;
        give_verdict();
    end
endmodule // test_ufp_top
